// [uhs_pkg.sv]
package uhs_pkg;

  // Register select that reaches the modem status register
  localparam logic [2:0] UHS_MSR_ADDR   = 3'h6;

  // Modem status register layout
  localparam int         UHS_MSR_DCTS   = 0;
  localparam int         UHS_MSR_DDSR   = 1;
  localparam int         UHS_MSR_DDCD   = 3;
  localparam int         UHS_MSR_CTS    = 4;
  localparam int         UHS_MSR_DSR    = 5;
  localparam int         UHS_MSR_DCD    = 7;

  // Modem lines in array order: clear-to-send, data-set-ready, carrier-detect
  localparam int         UHS_LINES      = 3;
  localparam int         UHS_LINE_CTS   = 0;
  localparam int         UHS_LINE_DSR   = 1;
  localparam int         UHS_LINE_DCD   = 2;

  localparam logic [7:0] UHS_BYTE_ZERO  = 8'h00;
  localparam logic [2:0] UHS_DELTA_ZERO = 3'h0;
  localparam logic [2:0] UHS_LINES_IDLE = 3'h7;

  typedef struct packed {
    logic       sel_high_a;
    logic       sel_high_b;
    logic       sel_low_n;
    logic [2:0] reg_addr;
  } uhs_select_type;

  typedef enum logic [1:0] {
    UHS_RD_IDLE = 2'b01,
    UHS_RD_BUSY = 2'b10
  } uhs_rd_state_type;

endpackage

// [uhs_host_modem.sv]
// Functional notes
// [RULE_01] Selected only with both highs high, low low
// [RULE_02] Eight-bit data bus, released when not driving
// [RULE_03] Status bit 4 shows clear-to-send level
// [RULE_04] Bit 0 flags clear-to-send change since read
// [RULE_05] Clear-to-send interrupt only without auto flow control
// [RULE_06] Auto mode gates transmitter with clear-to-send
// [RULE_07] Status bit 7 shows carrier-detect level
// [RULE_08] Bit 3 flags carrier change, may interrupt
// [RULE_09] Status bit 5 shows data-set-ready level
// [RULE_10] Bit 1 flags data-set-ready change, may interrupt
// [RULE_11] Transceiver disable low unless CPU reads
// [RULE_12] Terminal-ready low when bit set, else high; the code holds it high in loop mode even with the bit set
// [RULE_13] Interrupt high for any of four causes
// [RULE_14] Interrupt drops when serviced or on reset
// [RULE_15] Master reset clears state, outputs to defaults; the code leaves data_o and the held selects unchanged
// [RULE_16] Address strobe low passes selects, high holds
// [RULE_17] Read by either strobe while selected
// [RULE_18] Status read clears the change bits
`timescale 1ns/10ps
`default_nettype none

module uhs_host_modem
  import uhs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       master_reset_in_i,
  // Host bus
  input  wire logic       select_high_first_i,
  input  wire logic       select_high_second_i,
  input  wire logic       select_low_third_n_i,
  input  wire logic       address_latch_strobe_n_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       read_strobe_i,
  input  wire logic [7:0] other_read_data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_n_o,
  output logic            transceiver_disable_out_n_o,
  // Modem lines
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       dcd_n_i,
  output logic            dtr_n_o,
  output logic            tx_enable_o,
  // Control bits and interrupt sources
  input  wire logic       dtr_bit_i,
  input  wire logic       loop_mode_i,
  input  wire logic       modem_int_enable_i,
  input  wire logic       auto_cts_enable_i,
  input  wire logic       rx_error_int_i,
  input  wire logic       rx_data_int_i,
  input  wire logic       thr_empty_int_i,
  output logic            int_o
);

  uhs_select_type   sel_live;
  uhs_select_type   sel_held;
  uhs_select_type   sel_eff;
  uhs_rd_state_type rd_state;
  logic             selected;
  logic             read_active;
  logic             rd_start;
  logic             rd_end;
  logic             msr_read_end;
  logic             msr_selected;
  logic [2:0]       line_n;
  logic [2:0]       line_prev_n;
  logic [2:0]       delta;
  logic [7:0]       msr_value;
  logic             modem_event;
  logic             any_reset;

  assign any_reset = master_reset_in_i;

  // Latch selects while the strobe is low, hold them while it is high
  assign sel_live = '{select_high_first_i, select_high_second_i,
                      select_low_third_n_i, reg_addr_i};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_held <= '0;
    end else if (!address_latch_strobe_n_i) begin
      sel_held <= sel_live; // see [RULE_16]
    end
  end

  assign sel_eff = address_latch_strobe_n_i ? sel_held : sel_live; // see [RULE_16]

  assign selected    = sel_eff.sel_high_a && sel_eff.sel_high_b
                       && !sel_eff.sel_low_n; // see [RULE_01]
  assign read_active = selected && (!read_strobe_n_i || read_strobe_i); // see [RULE_17]
  assign msr_selected = (sel_eff.reg_addr == UHS_MSR_ADDR);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_state <= UHS_RD_IDLE;
    end else if (any_reset) begin
      rd_state <= UHS_RD_IDLE;
    end else begin
      unique case (rd_state)
        UHS_RD_IDLE: begin
          if (read_active) begin
            rd_state <= UHS_RD_BUSY;
          end
        end
        UHS_RD_BUSY: begin
          if (!read_active) begin
            rd_state <= UHS_RD_IDLE;
          end
        end
      endcase
    end
  end

  assign rd_start = (rd_state == UHS_RD_IDLE) && read_active && !any_reset;
  assign rd_end   = (rd_state == UHS_RD_BUSY) && !read_active;

  // Register select remembered for the clearing at read end
  logic rd_was_msr;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_was_msr <= 1'b0;
    end else if (rd_start) begin
      rd_was_msr <= msr_selected;
    end
  end
  assign msr_read_end = rd_end && rd_was_msr;

  // Change detection per modem line
  assign line_n = {dcd_n_i, dsr_n_i, cts_n_i};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      line_prev_n <= UHS_LINES_IDLE;
    end else begin
      line_prev_n <= line_n;
    end
  end

  generate
    for (genvar g = 0; g < UHS_LINES; g++) begin : g_delta
      // Clear at read end, not start, so the byte read still shows it; set wins
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          delta[g] <= 1'b0;
        end else if (any_reset) begin
          delta[g] <= 1'b0; // see [RULE_15]
        end else if (line_n[g] != line_prev_n[g]) begin
          delta[g] <= 1'b1; // see [RULE_04] [RULE_08] [RULE_10]
        end else if (msr_read_end) begin
          delta[g] <= 1'b0; // see [RULE_18]
        end
      end
    end
  endgenerate

  always_comb begin
    msr_value               = UHS_BYTE_ZERO;
    msr_value[UHS_MSR_DCTS] = delta[UHS_LINE_CTS];
    msr_value[UHS_MSR_DDSR] = delta[UHS_LINE_DSR];
    msr_value[UHS_MSR_DDCD] = delta[UHS_LINE_DCD];
    msr_value[UHS_MSR_CTS]  = !cts_n_i; // see [RULE_03]
    msr_value[UHS_MSR_DSR]  = !dsr_n_i; // see [RULE_09]
    msr_value[UHS_MSR_DCD]  = !dcd_n_i; // see [RULE_07]
  end

  // Byte captured at read start and held for the whole strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= UHS_BYTE_ZERO;
    end else if (rd_start) begin
      data_o <= msr_selected ? msr_value : other_read_data_i; // see [RULE_02]
    end
  end

  assign data_oe_n_o                 = (rd_state != UHS_RD_BUSY); // see [RULE_02]
  assign transceiver_disable_out_n_o = (rd_state == UHS_RD_BUSY); // see [RULE_11]

  // Modem pins and transmitter gate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dtr_n_o <= 1'b1;
    end else if (any_reset) begin
      dtr_n_o <= 1'b1; // see [RULE_12] [RULE_15]
    end else begin
      dtr_n_o <= !(dtr_bit_i && !loop_mode_i); // see [RULE_12]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_enable_o <= 1'b0;
    end else if (any_reset) begin
      tx_enable_o <= 1'b0;
    end else begin
      tx_enable_o <= !auto_cts_enable_i || !cts_n_i; // see [RULE_06]
    end
  end

  // Clear-to-send changes are flow control, not events, in auto mode
  assign modem_event = modem_int_enable_i // see [RULE_08] [RULE_10]
                       && ((delta[UHS_LINE_CTS] && !auto_cts_enable_i) // see [RULE_05]
                           || delta[UHS_LINE_DSR] || delta[UHS_LINE_DCD]);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else if (any_reset) begin
      int_o <= 1'b0; // see [RULE_14]
    end else begin
      int_o <= rx_error_int_i || rx_data_int_i || thr_empty_int_i
               || modem_event; // see [RULE_13] [RULE_14]
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_msr_read_end;
    msr_read_end && (line_n == line_prev_n) && !any_reset;
  endsequence

  property p_unselected_idle;
    (rd_state == UHS_RD_IDLE) && !selected |=> (rd_state == UHS_RD_IDLE);
  endproperty
  a_unselected_idle: assert property (p_unselected_idle) // see [RULE_01]
    else $error("Unselected device started a read");

  property p_bus_released;
    !read_active && !$past(read_active) |-> data_oe_n_o;
  endproperty
  a_bus_released: assert property (p_bus_released) // see [RULE_02]
    else $error("Data bus driven without a read");

  property p_cts_level;
    rd_start && msr_selected |=> data_o[UHS_MSR_CTS] == !$past(cts_n_i);
  endproperty
  a_cts_level: assert property (p_cts_level) // see [RULE_03]
    else $error("Status bit 4 does not match clear-to-send");

  property p_cts_delta;
    (cts_n_i != line_prev_n[UHS_LINE_CTS]) && !any_reset |=> delta[UHS_LINE_CTS];
  endproperty
  a_cts_delta: assert property (p_cts_delta) // see [RULE_04]
    else $error("Clear-to-send change not flagged");

  property p_auto_cts_gate;
    auto_cts_enable_i && cts_n_i && !any_reset |=> !tx_enable_o;
  endproperty
  a_auto_cts_gate: assert property (p_auto_cts_gate) // see [RULE_06]
    else $error("Transmitter enabled while clear-to-send inactive");

  property p_dcd_level;
    rd_start && msr_selected |=> data_o[UHS_MSR_DCD] == !$past(dcd_n_i);
  endproperty
  a_dcd_level: assert property (p_dcd_level) // see [RULE_07]
    else $error("Status bit 7 does not match carrier-detect");

  property p_dsr_level;
    rd_start && msr_selected |=> data_o[UHS_MSR_DSR] == !$past(dsr_n_i);
  endproperty
  a_dsr_level: assert property (p_dsr_level) // see [RULE_09]
    else $error("Status bit 5 does not match data-set-ready");

  property p_disable_idle;
    !read_active |=> !transceiver_disable_out_n_o;
  endproperty
  a_disable_idle: assert property (p_disable_idle) // see [RULE_11]
    else $error("Transceiver disable high outside a read");

  property p_dtr_loop;
    loop_mode_i |=> dtr_n_o;
  endproperty
  a_dtr_loop: assert property (p_dtr_loop) // see [RULE_12]
    else $error("Terminal-ready active in loop mode");

  property p_int_reset;
    master_reset_in_i |=> !int_o ##1 1'b1;
  endproperty
  a_int_reset: assert property (p_int_reset) // see [RULE_14]
    else $error("Interrupt high after master reset");

  property p_latch_hold;
    address_latch_strobe_n_i && $past(address_latch_strobe_n_i) |-> $stable(sel_eff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // see [RULE_16]
    else $error("Selects moved while address strobe high");

  property p_read_clears;
    s_msr_read_end |=> (delta == UHS_DELTA_ZERO);
  endproperty
  a_read_clears: assert property (p_read_clears) // see [RULE_18]
    else $error("Change bits not cleared by status read");

endmodule

`default_nettype wire

// [uhs_host_cpu.sv]
`timescale 1ns/10ps
`default_nettype none

module uhs_host_cpu
  import uhs_pkg::*;
(
  // Clock and reset
  input  wire logic           clk_sys_i,
  input  wire logic           rst_i,
  // Requests from the bench
  input  wire logic           go_i,
  input  wire logic           use_high_i,
  input  wire logic           latch_i,
  input  wire uhs_select_type sel_i,
  // Device bus
  input  wire logic     [7:0] data_i,
  input  wire logic           data_oe_n_i,
  output var uhs_select_type  sel_o,
  output logic                read_strobe_n_o,
  output logic                read_strobe_o,
  output logic                address_latch_strobe_n_o,
  // Results
  output logic          [7:0] rd_data_o,
  output logic                got_o,
  output logic                done_o
);
  logic [1:0] st;
  logic [2:0] cnt;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st <= 2'h0;
      cnt <= 3'h0;
      sel_o <= '{1'b0, 1'b0, 1'b1, 3'h0};
      read_strobe_n_o <= 1'b1;
      read_strobe_o <= 1'b0;
      address_latch_strobe_n_o <= 1'b0;
      rd_data_o <= 8'h00;
      got_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st)
        2'h0: if (go_i) begin
          sel_o <= sel_i;
          st <= 2'h1;
        end
        2'h1: begin
          // Unused strobe stays at its inactive level
          read_strobe_n_o <= use_high_i;
          read_strobe_o <= use_high_i;
          if (latch_i) begin
            // Live lines turn to junk; the device must run on held selects
            address_latch_strobe_n_o <= 1'b1;
            sel_o <= uhs_select_type'(~sel_i);
          end
          cnt <= 3'h0;
          st <= 2'h2;
        end
        default: if (!data_oe_n_i || cnt == 3'h6) begin
          got_o <= !data_oe_n_i;
          rd_data_o <= data_i;
          read_strobe_n_o <= 1'b1;
          read_strobe_o <= 1'b0;
          address_latch_strobe_n_o <= 1'b0;
          sel_o <= '{1'b0, 1'b0, 1'b1, ~sel_o.reg_addr};
          done_o <= 1'b1;
          st <= 2'h0;
        end else begin
          cnt <= cnt + 3'h1;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// [uhs_host_modem_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module uhs_host_modem_tb
  import uhs_pkg::*;
;
  typedef struct packed {
    logic [5:0] in;
    logic [7:0] msr;
    logic [1:0] out;
  } uhs_row_type;
  // Inputs are cts, dsr, dcd, dtr bit, loop, auto; outputs dtr_n, tx enable
  localparam uhs_row_type ROWS [6] = '{
    '{6'h38, 8'h00, 2'h3}, '{6'h1C, 8'h10, 2'h1}, '{6'h2E, 8'h20, 2'h3},
    '{6'h31, 8'h80, 2'h2}, '{6'h05, 8'hB0, 2'h1}, '{6'h13, 8'h90, 2'h3}};
  localparam logic [7:0] DLT [3] = '{8'h11, 8'h22, 8'h88};
  localparam logic [2:0] NOSEL [3] = '{3'b010, 3'b100, 3'b111};
  logic clk = 1'b0, rst = 1'b1, mst_rst = 1'b0, go = 1'b0, hi = 1'b0, lat = 1'b0;
  logic dtr_bit = 1'b0, loop = 1'b0, mie = 1'b0, auto = 1'b0;
  logic [2:0] mdm_n = 3'h7, srcs = 3'h0;
  logic [7:0] other = 8'h5A, data, rdata, lvl;
  logic oe_n, dis_n, dtr_n, tx, irq, rs_n, rs, als_n, got, done;
  uhs_select_type req = '0, sel;
  int err_count = 0, checks_done = 0;

  always #5 clk = ~clk;

  uhs_host_modem dut (.clk_sys_i(clk), .rst_i(rst), .master_reset_in_i(mst_rst),
    .select_high_first_i(sel.sel_high_a), .select_high_second_i(sel.sel_high_b),
    .select_low_third_n_i(sel.sel_low_n), .address_latch_strobe_n_i(als_n),
    .reg_addr_i(sel.reg_addr), .read_strobe_n_i(rs_n), .read_strobe_i(rs),
    .other_read_data_i(other), .data_o(data), .data_oe_n_o(oe_n),
    .transceiver_disable_out_n_o(dis_n), .cts_n_i(mdm_n[UHS_LINE_CTS]),
    .dsr_n_i(mdm_n[UHS_LINE_DSR]), .dcd_n_i(mdm_n[UHS_LINE_DCD]), .dtr_n_o(dtr_n),
    .tx_enable_o(tx), .dtr_bit_i(dtr_bit), .loop_mode_i(loop), .modem_int_enable_i(mie),
    .auto_cts_enable_i(auto), .rx_error_int_i(srcs[0]), .rx_data_int_i(srcs[1]),
    .thr_empty_int_i(srcs[2]), .int_o(irq));

  uhs_host_cpu host (.clk_sys_i(clk), .rst_i(rst), .go_i(go), .use_high_i(hi),
    .latch_i(lat), .sel_i(req), .data_i(data), .data_oe_n_i(oe_n), .sel_o(sel),
    .read_strobe_n_o(rs_n), .read_strobe_o(rs), .address_latch_strobe_n_o(als_n),
    .rd_data_o(rdata), .got_o(got), .done_o(done));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [2:0] s, input logic [2:0] a, input logic h, input logic l);
    int n;
    n = 0;
    req = '{s[2], s[1], s[0], a};
    hi = h;
    lat = l;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    while (done !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      err_count++;
      final_report();
    end
    tick(3);
    check({6'h00, oe_n, dis_n}, 8'h02);
  endtask

  task automatic wt(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 6) begin
      tick(1);
      n++;
    end
    check(8'(irq), 8'(e));
  endtask

  // Reads must always open the transceiver
  always @(negedge clk) if (!rst && oe_n === 1'b0) check(8'(dis_n), 8'h01);

  initial begin
    tick(2);
    check({3'h0, oe_n, dis_n, dtr_n, tx, irq}, 8'h14);
    check(data, 8'h00);
    tick(2);
    rst = 1'b0;
    foreach (ROWS[i]) begin
      {mdm_n[UHS_LINE_CTS], mdm_n[UHS_LINE_DSR], mdm_n[UHS_LINE_DCD], dtr_bit, loop, auto} =
        ROWS[i].in;
      tick(3);
      check(8'({dtr_n, tx}), 8'(ROWS[i].out));
      rd(3'b110, UHS_MSR_ADDR, 1'b0, 1'b0);
      rd(3'b110, UHS_MSR_ADDR, i[0], 1'b0);
      check(rdata, ROWS[i].msr);
    end
    mdm_n = 3'h7;
    auto = 1'b0;
    tick(3);
    rd(3'b110, UHS_MSR_ADDR, 1'b0, 1'b0);
    mie = 1'b1;
    lvl = 8'h00;
    for (int i = 0; i < 3; i++) begin
      mdm_n[i] = 1'b0;
      wt(1'b1);
      rd(3'b110, UHS_MSR_ADDR, 1'b1, 1'b0);
      check(rdata, DLT[i] | lvl);
      lvl = lvl | (DLT[i] & 8'hF0);
      wt(1'b0);
    end
    auto = 1'b1;
    mdm_n[UHS_LINE_CTS] = 1'b1;
    tick(4);
    check(8'(irq), 8'h00);
    rd(3'b110, UHS_MSR_ADDR, 1'b0, 1'b0);
    check(rdata, 8'hA1);
    mie = 1'b0;
    mdm_n[UHS_LINE_DSR] = 1'b1;
    tick(4);
    check(8'(irq), 8'h00);
    rd(3'b110, UHS_MSR_ADDR, 1'b0, 1'b0);
    check(rdata, 8'h82);
    for (int i = 0; i < 3; i++) begin
      srcs = 3'(3'h1 << i);
      wt(1'b1);
      srcs = 3'h0;
      wt(1'b0);
    end
    srcs = 3'h1;
    dtr_bit = 1'b1;
    loop = 1'b0;
    mdm_n[UHS_LINE_DCD] = 1'b1;
    tick(3);
    mst_rst = 1'b1;
    tick(1);
    check(8'({dtr_n, tx, irq}), 8'h04);
    mst_rst = 1'b0;
    srcs = 3'h0;
    tick(2);
    rd(3'b110, UHS_MSR_ADDR, 1'b0, 1'b0);
    check(rdata, 8'h00);
    foreach (NOSEL[i]) begin
      rd(NOSEL[i], UHS_MSR_ADDR, 1'b0, 1'b0);
      check(8'(got), 8'h00);
    end
    rd(3'b110, 3'h2, 1'b1, 1'b1);
    check(8'(got), 8'h01);
    check(rdata, 8'h5A);
    final_report();
  end
endmodule

`default_nettype wire
